/* File: hdl/stw_pkg.sv */
// Shared constants for the three-wire sensor readout link.
// Assumes both ends run on one 25 MHz system clock.
package stw_pkg;
  localparam int          START_BITS     = 3;
  localparam int          STOP_BITS      = 3;
  localparam int          SETUP_BITS     = 4;
  localparam int          FRAME_BITS     = START_BITS + SETUP_BITS + STOP_BITS;
  localparam int          WORD_BITS      = 16;
  localparam int          READ_CLOCKS    = 17;
  localparam int          ACK_CLOCKS     = 2;
  localparam int          RESET_BITS     = 21;
  localparam logic [3:0]  SETUP_PRESSURE = 4'hA;
  localparam logic [3:0]  SETUP_TEMP     = 4'h9;
  localparam logic [3:0]  SETUP_CAL1     = 4'h5;
  localparam logic [3:0]  SETUP_CAL2     = 4'h6;
  localparam logic [3:0]  SETUP_CAL3     = 4'h3;
  localparam logic [3:0]  SETUP_CAL4     = 4'hC;
  localparam logic [20:0] RESET_PATTERN  = 21'h155540;
  localparam logic [63:0] CALIB_DEFAULT  = 64'h1234_5678_9ABC_DEF0;
  localparam int          CONV_MCLKS     = 1000;
  localparam int          SCLK_HALF      = 4;
  localparam int          SYS_CLK_HZ     = 25000000;
  localparam int          MCLK_HZ        = 32768;
  localparam int          MCLK_HALF      = SYS_CLK_HZ / MCLK_HZ / 2;
  typedef enum logic [2:0] {
    STW_CMD_PRESSURE,
    STW_CMD_TEMP,
    STW_CMD_CAL1,
    STW_CMD_CAL2,
    STW_CMD_CAL3,
    STW_CMD_CAL4,
    STW_CMD_RESET
  } stw_cmd_t;
endpackage

/* File: hdl/stw_if.sv */
// Three-wire link between host and sensor end.
// Assumes the bench supplies the system clock and reset.
`timescale 1ns/100ps
interface stw_if;
  logic sclk;
  logic din;
  logic dout;
  logic mclk;
  modport sensor (input sclk, input din, input mclk, output dout);
  modport host   (output sclk, output din, input dout);
endinterface

/* File: hdl/stw_sensor.sv */
// Sensor end: instruction decode, conversion status and data shift-out.
// Assumes SCLK, DIN and MCLK are asynchronous pins, sampled by CLOCK.
// Behaviour
// R01: Sample instruction bits on serial clock rise
// R02: Launch output bits on serial clock rise
// R03: Host samples and changes on falling edge
// R04: Host alone generates the serial clock
// R05: Instruction selects result or calibration output
// R06: Output line also shows conversion status
// R07: Pressure, temperature, four calibration reads, reset
// R08: Three high start bits precede setup
// R09: Three low stop bits follow setup
// R10: Four-bit setup field selects operation
// R11: Output rises to acknowledge conversion start
// R12: Host gives two clocks, then holds low
// R13: Output falls when conversion completes
// R14: Seventeen clocks shift out sixteen-bit result
// R15: Paused serial clock resumes at same bit
// R16: Host reads result before next conversion
// R17: Reset pattern recognised in every state
// R18: Host ignores output during reset pattern
// R19: Host sends reset before first conversion
// R20: Conversion timed by separate master clock
// R21: Sixty-four calibration bits as four blocks
// R22: Setup codes parameters; words MSB first
// R23: Calibration read shifts directly after stop
`timescale 1ns/100ps
module stw_sensor
  import stw_pkg::*;
#(
  parameter logic [63:0] CALIB      = CALIB_DEFAULT,
  parameter int          CONV_TICKS = CONV_MCLKS
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  stw_if.sensor            LINK,
  input  wire logic [15:0] PRESSURE_SAMPLE,
  input  wire logic [15:0] TEMPERATURE_SAMPLE,
  output logic             CONV_BUSY,
  output logic             CONV_IS_PRESSURE
);
  typedef enum {S_START, S_SETUP, S_STOP, S_ACK, S_CONV, S_SHIFT} stw_sst_t;

  logic [1:0]  sclk_s_r, din_s_r, mclk_s_r;
  logic        sclk_d_r, mclk_d_r;
  logic        rise, mclk_rise;
  stw_sst_t    st_r;
  logic [3:0]  cnt_r;
  logic [3:0]  setup_r;
  logic [20:0] hist_r;
  logic [15:0] shift_r;
  logic [4:0]  bits_r;
  logic        dout_r;
  logic        conv_p_r;
  logic [15:0] conv_cnt_r;
  logic        reset_hit;
  logic [20:0] hist_nxt;

  // One 16-bit calibration block; block 1 sits in the top bits of CALIB
  function automatic logic [15:0] calib_block(input logic [1:0] idx);
    calib_block = CALIB[63 - 16 * int'(idx) -: 16];
  endfunction

  // Two-stage synchronisers for all pins
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      sclk_s_r <= 2'h0;
      din_s_r  <= 2'h0;
      mclk_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
      mclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], LINK.sclk};
      din_s_r  <= {din_s_r[0], LINK.din};
      mclk_s_r <= {mclk_s_r[0], LINK.mclk};
      sclk_d_r <= sclk_s_r[1];
      mclk_d_r <= mclk_s_r[1];
    end
  end

  assign rise      = sclk_s_r[1] & ~sclk_d_r; // R01 R02 R04
  assign mclk_rise = mclk_s_r[1] & ~mclk_d_r;
  assign hist_nxt  = {hist_r[19:0], din_s_r[1]};
  assign reset_hit = rise && (hist_nxt == RESET_PATTERN); // R17

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      hist_r <= 21'h0;
    end else if (rise) begin
      hist_r <= reset_hit ? 21'h0 : hist_nxt;
    end
  end

  // Protocol sequencer
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st_r       <= S_START;
      cnt_r      <= 4'h0;
      setup_r    <= 4'h0;
      shift_r    <= 16'h0;
      bits_r     <= 5'h0;
      dout_r     <= 1'b0;
      conv_p_r   <= 1'b0;
      conv_cnt_r <= 16'h0;
    end else if (reset_hit) begin
      st_r   <= S_START; // R17
      cnt_r  <= 4'h0;
      dout_r <= 1'b0;
    end else begin
      unique case (st_r)
        S_START: if (rise) begin
          if (din_s_r[1]) begin
            if (cnt_r == 4'(START_BITS - 1)) begin // R08
              st_r  <= S_SETUP;
              cnt_r <= 4'h0;
            end else begin
              cnt_r <= cnt_r + 4'h1;
            end
          end else begin
            cnt_r <= 4'h0;
          end
        end
        S_SETUP: if (rise) begin
          setup_r <= {setup_r[2:0], din_s_r[1]}; // R10
          if (cnt_r == 4'(SETUP_BITS - 1)) begin
            st_r  <= S_STOP;
            cnt_r <= 4'h0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        S_STOP: if (rise) begin
          if (din_s_r[1]) begin
            st_r  <= S_START; // R09
            cnt_r <= 4'h0;
          end else if (cnt_r == 4'(STOP_BITS - 1)) begin
            cnt_r <= 4'h0;
            bits_r <= 5'h0;
            unique case (setup_r) // R05 R07 R22
              SETUP_PRESSURE: begin
                st_r     <= S_ACK;
                conv_p_r <= 1'b1;
                dout_r   <= 1'b1; // R11 R06
              end
              SETUP_TEMP: begin
                st_r     <= S_ACK;
                conv_p_r <= 1'b0;
                dout_r   <= 1'b1; // R11 R06
              end
              SETUP_CAL1: begin
                st_r    <= S_SHIFT; // R23
                shift_r <= calib_block(2'h0); // R21
              end
              SETUP_CAL2: begin
                st_r    <= S_SHIFT;
                shift_r <= calib_block(2'h1);
              end
              SETUP_CAL3: begin
                st_r    <= S_SHIFT;
                shift_r <= calib_block(2'h2);
              end
              SETUP_CAL4: begin
                st_r    <= S_SHIFT;
                shift_r <= calib_block(2'h3);
              end
              default: st_r <= S_START;
            endcase
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        S_ACK: if (rise) begin
          if (cnt_r == 4'(ACK_CLOCKS - 1)) begin // R12
            st_r       <= S_CONV;
            conv_cnt_r <= 16'h0;
            cnt_r      <= 4'h0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        // Conversion counts master clock rises only; SCLK is looked at only for the reset pattern
        S_CONV: if (mclk_rise) begin // R20
          if (conv_cnt_r == 16'(CONV_TICKS - 1)) begin
            st_r    <= S_SHIFT;
            dout_r  <= 1'b0; // R13 R06
            shift_r <= conv_p_r ? PRESSURE_SAMPLE : TEMPERATURE_SAMPLE;
          end else begin
            conv_cnt_r <= conv_cnt_r + 16'h1;
          end
        end
        S_SHIFT: if (rise) begin // R15
          // Each rise launches the next bit, MSB first; last rise idles line
          if (bits_r == 5'(READ_CLOCKS - 1)) begin // R14
            st_r   <= S_START;
            dout_r <= 1'b0;
          end else begin
            dout_r  <= shift_r[15]; // R02 R22
            shift_r <= {shift_r[14:0], 1'b0};
            bits_r  <= bits_r + 5'h1;
          end
        end
      endcase
    end
  end

  assign LINK.dout        = dout_r;
  assign CONV_BUSY        = (st_r == S_ACK) || (st_r == S_CONV);
  assign CONV_IS_PRESSURE = conv_p_r;
endmodule

/* File: hdl/stw_host.sv */
// Host end: drives SCLK and DIN, issues instructions and collects words.
// Assumes DOUT is an asynchronous pin and CMD_VALID comes from CLOCK logic.
`timescale 1ns/100ps
module stw_host
  import stw_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  stw_if.host              LINK,
  input  wire logic        CMD_VALID,
  input  wire stw_cmd_t    CMD,
  output logic             CMD_READY,
  output logic             RESULT_VALID,
  output logic [15:0]      RESULT_DATA
);
  typedef enum {H_IDLE, H_SEND, H_WAITACK, H_ACKCLK, H_WAITEOC, H_READ} stw_hst_t;

  stw_hst_t    st_r;
  logic [1:0]  dout_s_r;
  logic [20:0] frame_r;
  logic [4:0]  left_r;
  logic [3:0]  div_r;
  logic        sclk_r, din_r;
  logic        conv_r;
  logic [15:0] data_r;
  logic        valid_r;
  logic        cal_r;
  logic [3:0]  code;

  always_comb begin
    unique case (CMD)
      STW_CMD_PRESSURE: code = SETUP_PRESSURE;
      STW_CMD_TEMP:     code = SETUP_TEMP;
      STW_CMD_CAL1:     code = SETUP_CAL1;
      STW_CMD_CAL2:     code = SETUP_CAL2;
      STW_CMD_CAL3:     code = SETUP_CAL3;
      STW_CMD_CAL4:     code = SETUP_CAL4;
      default:          code = 4'h0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      dout_s_r <= 2'h0;
    end else begin
      dout_s_r <= {dout_s_r[0], LINK.dout};
    end
  end

  // Host generates SCLK by dividing CLOCK; changes DIN and samples on fall
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st_r    <= H_IDLE;
      frame_r <= 21'h0;
      left_r  <= 5'h0;
      div_r   <= 4'h0;
      sclk_r  <= 1'b0;
      din_r   <= 1'b0;
      conv_r  <= 1'b0;
      data_r  <= 16'h0;
      cal_r   <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      if (st_r == H_IDLE) begin
        if (CMD_VALID) begin
          div_r <= 4'h0;
          if (CMD == STW_CMD_RESET) begin
            frame_r <= RESET_PATTERN; // R17
            left_r  <= 5'(RESET_BITS);
          end else begin
            frame_r <= {3'h7, code, 3'h0, 11'h0}; // R08 R09 R10
            left_r  <= 5'(FRAME_BITS);
          end
          conv_r <= (CMD == STW_CMD_PRESSURE) || (CMD == STW_CMD_TEMP);
          cal_r  <= (CMD != STW_CMD_PRESSURE) && (CMD != STW_CMD_TEMP) &&
                    (CMD != STW_CMD_RESET);
          din_r  <= (CMD == STW_CMD_RESET) ? RESET_PATTERN[20] : 1'b1;
          st_r   <= H_SEND;
        end
      end else if (st_r == H_WAITACK) begin
        if (dout_s_r[1]) begin // R11
          st_r   <= H_ACKCLK;
          left_r <= 5'(ACK_CLOCKS); // R12
        end
      end else if (st_r == H_WAITEOC) begin
        if (!dout_s_r[1]) begin // R13
          st_r   <= H_READ;
          left_r <= 5'(READ_CLOCKS); // R14
        end
      end else if (div_r == 4'(SCLK_HALF - 1)) begin
        div_r  <= 4'h0;
        sclk_r <= ~sclk_r; // R04
        if (sclk_r) begin // R03
          left_r <= left_r - 5'h1;
          // DOUT is not looked at while a frame is shifted out
          if (st_r == H_SEND) begin // R18
            frame_r <= {frame_r[19:0], 1'b0};
            din_r   <= frame_r[19];
          end
          if (st_r == H_READ && left_r != 5'(READ_CLOCKS)) begin
            data_r <= {data_r[14:0], dout_s_r[1]};
          end
          if (left_r == 5'h1) begin
            din_r <= 1'b0;
            unique case (st_r)
              H_SEND:   st_r <= conv_r ? H_WAITACK : (cal_r ? H_READ : H_IDLE);
              H_ACKCLK: st_r <= H_WAITEOC;
              default: begin
                st_r    <= H_IDLE;
                valid_r <= 1'b1;
              end
            endcase
            if (st_r == H_SEND && cal_r) begin
              left_r <= 5'(READ_CLOCKS);
            end
          end
        end
      end else begin
        div_r <= div_r + 4'h1;
      end
    end
  end

  assign LINK.sclk    = sclk_r;
  assign LINK.din     = din_r;
  assign CMD_READY    = (st_r == H_IDLE); // R16
  assign RESULT_VALID = valid_r;
  assign RESULT_DATA  = data_r;
endmodule

/* File: bench/stw_sva.sv */
// Checker watching the three-wire link between host and sensor ends.
// Assumes one system clock and the host's SCLK half period of 4 cycles.
`timescale 1ns/100ps
module stw_sva #(
  parameter int CONV_TICKS = 4
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic mclk
);
  logic       sclk_q, mclk_q, dout_q, din_q, post_r, eoc;
  logic [6:0] age_r;
  logic [7:0] mtk_r;
  logic [4:0] rise_r, rd_r;
  assign eoc = dout_q && !dout && age_r > 7'h08;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      {sclk_q, mclk_q, dout_q, din_q} <= 4'h0;
    end else begin
      {sclk_q, mclk_q, dout_q, din_q} <= {sclk, mclk, dout, din};
    end
  end
  // Cycles since the last SCLK rise, saturating
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      age_r <= 7'h7F;
    end else if (sclk && !sclk_q) begin
      age_r <= 7'h00;
    end else if (age_r != 7'h7F) begin
      age_r <= age_r + 7'h01;
    end
  end
  // SCLK rises since the last DOUT rise; MCLK rises since the last SCLK rise,
  // since the conversion only starts after the second clock past the ack
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rise_r <= 5'h00;
      mtk_r  <= 8'h00;
    end else begin
      rise_r <= (dout && !dout_q) ? 5'h00 : rise_r + 5'(sclk && !sclk_q);
      mtk_r  <= (sclk && !sclk_q) ? 8'h00 : mtk_r + 8'(mclk && !mclk_q);
    end
  end
  // Read clocks from end of conversion until the next start bit
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      post_r <= 1'h0;
      rd_r   <= 5'h00;
    end else if (eoc) begin
      post_r <= 1'h1;
      rd_r   <= 5'h00;
    end else begin
      post_r <= post_r && !(din && !din_q);
      rd_r   <= rd_r + 5'(sclk && !sclk_q);
    end
  end
  property p_din_on_fall;
    $changed(din) |-> !sclk;
  endproperty
  a_din_on_fall: assert property (p_din_on_fall) else $error("DIN moved with SCLK high");
  property p_sclk_shape;
    $rose(sclk) |-> sclk[*4] ##1 !sclk;
  endproperty
  a_sclk_shape: assert property (p_sclk_shape) else $error("SCLK pulse shape wrong");
  property p_launch_rise;
    $rose(dout) |-> age_r < 7'h08;
  endproperty
  a_launch_rise: assert property (p_launch_rise) else $error("DOUT rose without SCLK");
  property p_idle_fall;
    $changed(dout) && age_r > 7'h08 |-> !dout;
  endproperty
  a_idle_fall: assert property (p_idle_fall) else $error("DOUT rose while SCLK idle");
  property p_ack_held;
    $fell(dout) && age_r > 7'h08 |-> $past(dout, 8);
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("Acknowledge level too short");
  property p_two_clocks;
    $fell(dout) && age_r > 7'h08 |-> rise_r == 5'h02;
  endproperty
  a_two_clocks: assert property (p_two_clocks) else $error("Clocks after ack not two");
  property p_conv_time;
    eoc |-> mtk_r + 8'h01 >= 8'(CONV_TICKS) && mtk_r <= 8'(CONV_TICKS + 1);
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("Conversion length wrong");
  property p_read_17;
    post_r && $rose(din) |-> rd_r == 5'h11;
  endproperty
  a_read_17: assert property (p_read_17) else $error("Read clocks not seventeen");
  c_ack: cover property ($rose(dout) && age_r < 7'h08);
  c_eoc: cover property (eoc);
  c_read: cover property (post_r && $rose(din));
endmodule

/* File: bench/tb.sv */
// Bench joining host and sensor ends over one link, driving commands.
// Assumes the design package and interface are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tb;
  import stw_pkg::*;
  localparam logic [63:0] CALIB = 64'hA5C3_0F1E_7B2D_9640;
  localparam int          CT    = 4;
  logic        clock, resetn, cmd_valid, cmd_ready, res_valid, busy, is_p;
  stw_cmd_t    cmd;
  logic [15:0] ps, ts, res_data;
  logic [31:0] seed;
  logic [17:0] e;
  logic [17:0] q[$];
  int          num_errors, cmp_count, cyc;
  stw_if lnk();
  stw_sensor #(.CALIB(CALIB), .CONV_TICKS(CT)) u_stw_sensor (.CLOCK(clock), .RESETN(resetn),
    .LINK(lnk.sensor), .PRESSURE_SAMPLE(ps), .TEMPERATURE_SAMPLE(ts), .CONV_BUSY(busy),
    .CONV_IS_PRESSURE(is_p));
  stw_host u_stw_host (.CLOCK(clock), .RESETN(resetn), .LINK(lnk.host), .CMD_VALID(cmd_valid),
    .CMD(cmd), .CMD_READY(cmd_ready), .RESULT_VALID(res_valid), .RESULT_DATA(res_data));
  stw_sva #(.CONV_TICKS(CT)) u_stw_sva (.CLOCK(clock), .RESETN(resetn), .sclk(lnk.sclk),
    .din(lnk.din), .dout(lnk.dout), .mclk(lnk.mclk));
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  // Conversion clock, free running and out of phase with the system clock
  initial begin
    lnk.mclk = 1'h0;
    #7;
    forever #160 lnk.mclk = ~lnk.mclk;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic results();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic run(input stw_cmd_t c);
    logic [15:0] v;
    v = rnd();
    if (c == STW_CMD_PRESSURE) ps = v;
    if (c == STW_CMD_TEMP) ts = v;
    if (c <= STW_CMD_TEMP) q.push_back({1'h1, c == STW_CMD_PRESSURE, v});
    else if (c != STW_CMD_RESET) q.push_back({2'h0, CALIB[63 - 16 * (c - 2) -: 16]});
    cmd = c;
    cmd_valid = 1'h1;
    @(negedge clock);
    cmd_valid = 1'h0;
    while (cmd_ready !== 1'h1) @(negedge clock);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  // Each result is matched against the oldest expectation
  always @(posedge clock) begin
    if (resetn && res_valid === 1'h1) begin
      e = (q.size() > 0) ? q.pop_front() : 18'hX;
      `CHK(res_data, e[15:0])
      if (e[17]) `CHK(is_p, e[16])
      `CHK(busy, 1'h0)
    end
  end
  initial begin
    resetn = 1'h0;
    cmd_valid = 1'h0;
    cmd = STW_CMD_RESET;
    ps = 16'h0000;
    ts = 16'h0000;
    seed = 32'h0000309F;
    repeat (4) @(negedge clock);
    resetn = 1'h1;
    run(STW_CMD_RESET);
    for (int i = 0; i < 7; i++) run(stw_cmd_t'(i));
    repeat (12) run(stw_cmd_t'(rnd() % 7));
    // Reset lands early in a result read-out
    fork
      run(STW_CMD_PRESSURE);
      begin
        repeat (150) @(negedge clock);
        resetn = 1'h0;
        q.delete();
        repeat (4) @(negedge clock);
        resetn = 1'h1;
      end
    join
    run(STW_CMD_RESET);
    run(STW_CMD_CAL4);
    run(STW_CMD_TEMP);
    repeat (20) @(negedge clock);
    `CHK(q.size(), 0)
    results();
  end
endmodule
